//--- logic/pvl_pkg.sv
// Package with command codes, defaults, bit positions and carriers of the voltage limit bank.
package pvl_pkg;
  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_FMT = 8'h20;
  localparam logic [7:0] CMD_NOM = 8'h21;
  localparam logic [7:0] CMD_CEIL = 8'h24;
  localparam logic [7:0] CMD_MHI = 8'h25;
  localparam logic [7:0] CMD_MLO = 8'h26;
  localparam logic [7:0] CMD_INPUT_TURN_ON_LEVEL = 8'h35;
  localparam logic [7:0] CMD_INPUT_TURN_OFF_LEVEL = 8'h36;
  localparam logic [7:0] CMD_OVF = 8'h40;
  localparam logic [7:0] CMD_OVW = 8'h42;
  localparam logic [7:0] CMD_UVW = 8'h43;
  localparam logic [7:0] CMD_UVF = 8'h44;
  localparam logic [7:0] CMD_VIN_OVF = 8'h55;
  localparam logic [7:0] CMD_VIN_UVW = 8'h58;
  localparam logic [7:0] CMD_PG_ON = 8'h5e;
  localparam logic [7:0] CMD_PG_OFF = 8'h5f;
  localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
  localparam logic [7:0] CMD_STAT_WORD = 8'h79;
  localparam logic [7:0] CMD_STAT_VOUT = 8'h7a;
  localparam logic [7:0] CMD_ABS_CEIL = 8'ha5;
  localparam logic [7:0] CMD_COMMON = 8'hd1;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] FMT_RST = 8'h14;
  localparam logic [15:0] NOM_RST = 16'h1000;
  localparam logic [15:0] CEIL0_RST = 16'h4189;
  localparam logic [15:0] CEIL1_RST = 16'h5800;
  localparam logic [15:0] MHI_RST = 16'h10cd;
  localparam logic [15:0] MLO_RST = 16'h0f33;
  localparam logic [15:0] INPUT_TURN_ON_LEVEL_RST = 16'hcb40;
  localparam logic [15:0] INPUT_TURN_OFF_LEVEL_RST = 16'hcb00;
  localparam logic [15:0] OVF_RST = 16'h119a;
  localparam logic [15:0] OVW_RST = 16'h1133;
  localparam logic [15:0] UVW_RST = 16'h0ecd;
  localparam logic [15:0] UVF_RST = 16'h0e66;
  localparam logic [15:0] VIN_OVF_RST = 16'hd3e0;
  localparam logic [15:0] VIN_UVW_RST = 16'hcb26;
  localparam logic [15:0] PG_ON_RST = 16'h0ee1;
  localparam logic [15:0] PG_OFF_RST = 16'h0eb8;
  localparam logic [15:0] ABS0_RST = 16'h4189;
  localparam logic [15:0] ABS1_RST = 16'h5800;
  // ==========================================================================
  // Status bit positions
  localparam int SB_NOA = 0;
  localparam int SW_VOUT = 15;
  localparam int SW_INPUT = 13;
  localparam int SV_OVF = 7;
  localparam int SV_OVW = 6;
  localparam int SV_UVW = 5;
  localparam int SV_UVF = 4;
  localparam int CM_BUSY_A = 5;
  localparam int CM_BUSY_B = 6;
  localparam int CM_CML = 0;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int OV_RECALC_MS = 10;
  localparam int OV_RECALC_CYC = OV_RECALC_MS * (CLK_HZ / 1000);
  localparam int BUSY_W = 20;
  localparam int RAMP_TICK_CYC = 25;
  localparam int RAMP_W = 16;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {SEQ_OFF, SEQ_RISE, SEQ_ON, SEQ_FALL} pvl_seq_e;
  typedef enum logic [1:0] {OP_NOM, OP_MHI, OP_MLO} pvl_op_e;
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] code;
    logic [15:0] wdata;
  } pvl_cmd_s;
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } pvl_rsp_s;
  typedef struct packed {
    logic vin_vld;
    logic [15:0] vin;
    logic [1:0] vout_vld;
    logic [1:0][15:0] vout;
  } pvl_adc_s;
  typedef struct packed {
    logic [15:0] nom, ceil, mhi, mlo, ovf, ovw, uvw, uvf, pgon, pgoff, goal, vset;
    pvl_seq_e seq;
    logic pg, f_ov, w_ov, w_uv, f_uv, tg_en, bg_on;
  } pvl_chan_s;
  // Input words scaled to a common fixed point so signed exponents compare.
  function automatic logic signed [47:0] l11_val(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0] e;
    m = 48'(signed'(w[10:0]));
    e = w[15:11] + 5'h10;
    return m <<< e;
  endfunction
endpackage

//--- logic/pvl_bank.sv
// Voltage set-point and limit command bank for a dual-channel step-down controller.
`timescale 1ns/10ps
module pvl_bank
  import pvl_pkg::*;
#(
  parameter int RECALC_CYC = OV_RECALC_CYC,
  parameter int TICK_CYC = RAMP_TICK_CYC,
  parameter logic [15:0] ABS0 = ABS0_RST,
  parameter logic [15:0] ABS1 = ABS1_RST
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire pvl_cmd_s cmd,
  output pvl_rsp_s rsp,
  input wire pvl_adc_s adc,
  input wire logic [1:0] run,
  input wire pvl_op_e [1:0] op_mode,
  input wire logic [15:0] ramp_step,
  input wire logic [1:0] overvoltage_pulldown_response,
  output logic [1:0] top_gate_drive,
  output logic [1:0] bottom_gate_drive,
  output logic [1:0] power_good,
  output logic gpio_fault,
  output logic alert
);

  initial begin
    if (RECALC_CYC < 1 || RECALC_CYC >= (1 << BUSY_W) || TICK_CYC < 1 ||
        TICK_CYC >= (1 << RAMP_W)) begin
      $error("pvl_bank: parameter out of range");
    end
  end

  // ==========================================================================
  // State
  typedef struct packed {
    pvl_chan_s [1:0] ch;
    logic [15:0] input_turn_on_level, input_turn_off_level, vin_ovf, vin_uvw;
    logic page, vin_ok, vin_ov, vin_uv, memory_logic_fault;
    logic [BUSY_W-1:0] busy;
    logic [RAMP_W-1:0] tick;
    logic gpio;
    pvl_rsp_s rsp;
  } pvl_state_s;

  pvl_state_s s_q, s_d;
  logic [1:0][15:0] abs_ceil;
  logic [1:0][15:0] sb, sw, sv;
  logic [15:0] common;
  logic tick_now;

  assign abs_ceil[0] = ABS0;
  assign abs_ceil[1] = ABS1;
  assign tick_now = (s_q.tick == '0);

  // Status words are built from the sticky flags of each channel and of the input supply.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sv[i] = '0;
      sv[i][SV_OVF] = s_q.ch[i].f_ov;
      sv[i][SV_OVW] = s_q.ch[i].w_ov;
      sv[i][SV_UVW] = s_q.ch[i].w_uv;
      sv[i][SV_UVF] = s_q.ch[i].f_uv;
      sb[i] = '0;
      sb[i][SB_NOA] = s_q.ch[i].w_ov | s_q.ch[i].w_uv | s_q.ch[i].f_uv;
      sw[i] = sb[i];
      sw[i][SW_VOUT] = |sv[i];
      sw[i][SW_INPUT] = s_q.vin_ov | s_q.vin_uv;
    end
    common = 16'hffff;
    common[CM_BUSY_A] = (s_q.busy == '0);
    common[CM_BUSY_B] = (s_q.busy == '0);
    common[CM_CML] = s_q.memory_logic_fault;
  end

  // Moves a value toward its goal by one step, never past it.
  function automatic logic [15:0] ramp(input logic [15:0] v, input logic [15:0] g,
                                       input logic [15:0] st);
    logic [16:0] up;
    logic [15:0] s;
    s = (st == '0) ? 16'h0001 : st;
    up = {1'b0, v} + {1'b0, s};
    if (v < g) begin
      return (up >= {1'b0, g}) ? g : up[15:0];
    end else if (v > g) begin
      return (v - g <= s) ? g : v - s;
    end
    return v;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic [15:0] req;
    logic [15:0] lim;
    logic p;
    logic clr;
    logic signed [47:0] vin_v;
    req = '0;
    lim = '0;
    p = s_q.page;
    clr = cmd.req && cmd.we && (cmd.code == CMD_CLEAR);
    vin_v = l11_val(adc.vin);
    s_d = s_q;
    s_d.rsp = '0;
    s_d.tick = tick_now ? RAMP_W'(TICK_CYC - 1) : s_q.tick - 1'b1;
    s_d.busy = (s_q.busy != '0) ? s_q.busy - 1'b1 : s_q.busy;

    // Input supply checks, evaluated on every converted sample.
    if (clr) begin
      s_d.vin_ov = 1'b0;
      s_d.vin_uv = 1'b0;
      s_d.memory_logic_fault = 1'b0;
    end
    if (adc.vin_vld) begin
      if (vin_v > l11_val(s_q.vin_ovf)) s_d.vin_ov = 1'b1;
      if (vin_v < l11_val(s_q.vin_uvw)) s_d.vin_uv = 1'b1;
      if (vin_v >= l11_val(s_q.input_turn_on_level)) s_d.vin_ok = 1'b1;
      else if (vin_v <= l11_val(s_q.input_turn_off_level)) s_d.vin_ok = 1'b0;
    end

    for (int i = 0; i < 2; i++) begin
      // Output words share one exponent, so mantissas compare directly.
      unique case (op_mode[i])
        OP_MHI: req = s_q.ch[i].mhi;
        OP_MLO: req = s_q.ch[i].mlo;
        default: req = s_q.ch[i].nom;
      endcase
      lim = (s_q.ch[i].ceil < abs_ceil[i]) ? s_q.ch[i].ceil : abs_ceil[i];
      if (req > lim) req = lim;

      if (clr) begin
        s_d.ch[i].f_ov = 1'b0;
        s_d.ch[i].w_ov = 1'b0;
        s_d.ch[i].w_uv = 1'b0;
        s_d.ch[i].f_uv = 1'b0;
      end
      if (adc.vout_vld[i]) begin
        if (adc.vout[i] > s_q.ch[i].ovf) begin
          s_d.ch[i].f_ov = 1'b1;
          if (overvoltage_pulldown_response[i]) begin
            s_d.ch[i].tg_en = 1'b0;
            s_d.ch[i].bg_on = 1'b1;
          end
        end
        if (adc.vout[i] > s_q.ch[i].ovw) s_d.ch[i].w_ov = 1'b1;
        if (adc.vout[i] < s_q.ch[i].uvw) s_d.ch[i].w_uv = 1'b1;
        if (adc.vout[i] < s_q.ch[i].uvf) s_d.ch[i].f_uv = 1'b1;
        if (adc.vout[i] >= s_q.ch[i].pgon) s_d.ch[i].pg = 1'b1;
        else if (adc.vout[i] <= s_q.ch[i].pgoff) s_d.ch[i].pg = 1'b0;
      end

      // Sequencer. The goal tracks the request in the steady state and is loaded once on leaving off.
      unique case (s_q.ch[i].seq)
        SEQ_OFF: begin
          if (run[i] && s_q.vin_ok && !s_q.ch[i].f_ov) begin
            s_d.ch[i].seq = SEQ_RISE;
            s_d.ch[i].goal = req;
            s_d.ch[i].tg_en = 1'b1;
            s_d.ch[i].bg_on = 1'b0;
          end
        end
        SEQ_RISE: begin
          if (!run[i] || !s_q.vin_ok) s_d.ch[i].seq = SEQ_FALL;
          else if (s_q.ch[i].vset == s_q.ch[i].goal) s_d.ch[i].seq = SEQ_ON;
          if (tick_now) s_d.ch[i].vset = ramp(s_q.ch[i].vset, s_q.ch[i].goal, ramp_step);
        end
        SEQ_ON: begin
          s_d.ch[i].goal = req;
          if (!run[i] || !s_q.vin_ok) s_d.ch[i].seq = SEQ_FALL;
          if (tick_now) s_d.ch[i].vset = ramp(s_q.ch[i].vset, s_q.ch[i].goal, ramp_step);
        end
        SEQ_FALL: begin
          if (tick_now) s_d.ch[i].vset = ramp(s_q.ch[i].vset, '0, ramp_step);
          if (s_q.ch[i].vset == '0) begin
            s_d.ch[i].seq = SEQ_OFF;
            s_d.ch[i].tg_en = 1'b0;
          end
        end
      endcase
      // A lowered ceiling takes effect at once; the output never waits above it.
      if (s_d.ch[i].vset > lim) s_d.ch[i].vset = lim;
      if (s_d.ch[i].goal > lim) s_d.ch[i].goal = lim;
    end
    s_d.gpio = (s_q.ch[0].f_ov && !overvoltage_pulldown_response[0]) ||
               (s_q.ch[1].f_ov && !overvoltage_pulldown_response[1]);

    // Command port. A request is answered on the next edge.
    if (cmd.req) begin
      s_d.rsp.ack = 1'b1;
      if (cmd.we) begin
        unique case (cmd.code)
          CMD_PAGE: begin
            if (cmd.wdata[7:1] == '0) s_d.page = cmd.wdata[0];
            else s_d.rsp.err = 1'b1;
          end
          CMD_CLEAR: ;
          CMD_NOM: begin
            if (cmd.wdata > abs_ceil[p]) begin
              s_d.ch[p].nom = abs_ceil[p];
              s_d.memory_logic_fault = 1'b1;
            end else begin
              s_d.ch[p].nom = cmd.wdata;
            end
          end
          CMD_CEIL: begin
            s_d.ch[p].ceil = cmd.wdata;
            // A lowered ceiling clamps in the same edge, so no cycle runs above it.
            if (s_d.ch[p].vset > cmd.wdata) s_d.ch[p].vset = cmd.wdata;
            if (s_d.ch[p].goal > cmd.wdata) s_d.ch[p].goal = cmd.wdata;
          end
          CMD_MHI: s_d.ch[p].mhi = cmd.wdata;
          CMD_MLO: s_d.ch[p].mlo = cmd.wdata;
          CMD_INPUT_TURN_ON_LEVEL: s_d.input_turn_on_level = cmd.wdata;
          CMD_INPUT_TURN_OFF_LEVEL: s_d.input_turn_off_level = cmd.wdata;
          CMD_OVF: begin
            s_d.ch[p].ovf = cmd.wdata;
            // Protection thresholds are rebuilt while the switcher runs.
            if (s_q.ch[p].seq != SEQ_OFF) s_d.busy = BUSY_W'(RECALC_CYC);
          end
          CMD_OVW: s_d.ch[p].ovw = cmd.wdata;
          CMD_UVW: s_d.ch[p].uvw = cmd.wdata;
          CMD_UVF: s_d.ch[p].uvf = cmd.wdata;
          CMD_VIN_OVF: s_d.vin_ovf = cmd.wdata;
          CMD_VIN_UVW: s_d.vin_uvw = cmd.wdata;
          CMD_PG_ON: s_d.ch[p].pgon = cmd.wdata;
          CMD_PG_OFF: s_d.ch[p].pgoff = cmd.wdata;
          default: s_d.rsp.err = 1'b1;
        endcase
      end else begin
        unique case (cmd.code)
          CMD_PAGE: s_d.rsp.rdata = {15'h0000, s_q.page};
          CMD_FMT: s_d.rsp.rdata = {8'h00, FMT_RST};
          CMD_NOM: s_d.rsp.rdata = s_q.ch[p].nom;
          CMD_CEIL: s_d.rsp.rdata = s_q.ch[p].ceil;
          CMD_MHI: s_d.rsp.rdata = s_q.ch[p].mhi;
          CMD_MLO: s_d.rsp.rdata = s_q.ch[p].mlo;
          CMD_INPUT_TURN_ON_LEVEL: s_d.rsp.rdata = s_q.input_turn_on_level;
          CMD_INPUT_TURN_OFF_LEVEL: s_d.rsp.rdata = s_q.input_turn_off_level;
          CMD_OVF: s_d.rsp.rdata = s_q.ch[p].ovf;
          CMD_OVW: s_d.rsp.rdata = s_q.ch[p].ovw;
          CMD_UVW: s_d.rsp.rdata = s_q.ch[p].uvw;
          CMD_UVF: s_d.rsp.rdata = s_q.ch[p].uvf;
          CMD_VIN_OVF: s_d.rsp.rdata = s_q.vin_ovf;
          CMD_VIN_UVW: s_d.rsp.rdata = s_q.vin_uvw;
          CMD_PG_ON: s_d.rsp.rdata = s_q.ch[p].pgon;
          CMD_PG_OFF: s_d.rsp.rdata = s_q.ch[p].pgoff;
          CMD_STAT_BYTE: s_d.rsp.rdata = {8'h00, sb[p][7:0]};
          CMD_STAT_WORD: s_d.rsp.rdata = sw[p];
          CMD_STAT_VOUT: s_d.rsp.rdata = {8'h00, sv[p][7:0]};
          CMD_ABS_CEIL: s_d.rsp.rdata = abs_ceil[p];
          CMD_COMMON: s_d.rsp.rdata = common;
          default: s_d.rsp.err = 1'b1;
        endcase
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      for (int i = 0; i < 2; i++) begin
        s_q.ch[i].nom <= NOM_RST;
        s_q.ch[i].mhi <= MHI_RST;
        s_q.ch[i].mlo <= MLO_RST;
        s_q.ch[i].ovf <= OVF_RST;
        s_q.ch[i].ovw <= OVW_RST;
        s_q.ch[i].uvw <= UVW_RST;
        s_q.ch[i].uvf <= UVF_RST;
        s_q.ch[i].pgon <= PG_ON_RST;
        s_q.ch[i].pgoff <= PG_OFF_RST;
        s_q.ch[i].seq <= SEQ_OFF;
      end
      s_q.ch[0].ceil <= CEIL0_RST;
      s_q.ch[1].ceil <= CEIL1_RST;
      s_q.input_turn_on_level <= INPUT_TURN_ON_LEVEL_RST;
      s_q.input_turn_off_level <= INPUT_TURN_OFF_LEVEL_RST;
      s_q.vin_ovf <= VIN_OVF_RST;
      s_q.vin_uvw <= VIN_UVW_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp = s_q.rsp;
  assign gpio_fault = s_q.gpio;
  assign alert = (|sw[0]) | (|sw[1]);
  for (genvar g = 0; g < 2; g++) begin : g_out
    assign top_gate_drive[g] = s_q.ch[g].tg_en;
    assign bottom_gate_drive[g] = s_q.ch[g].bg_on;
    assign power_good[g] = s_q.ch[g].pg;
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_vin_ov_flag: assert property (adc.vin_vld && l11_val(adc.vin) > l11_val(s_q.vin_ovf)
    |=> s_q.vin_ov && alert) else $error("input overvoltage not flagged");
  a_vin_uv_warn: assert property (adc.vin_vld && l11_val(adc.vin) < l11_val(s_q.vin_uvw)
    |=> s_q.vin_uv) else $error("input undervoltage warning missed");
  a_start_needs_vin: assert property (s_q.ch[0].seq == SEQ_OFF && s_d.ch[0].seq == SEQ_RISE
    |-> s_q.vin_ok) else $error("conversion started without input");
  a_input_turn_off_level_stop: assert property (adc.vin_vld && l11_val(adc.vin) <= l11_val(s_q.input_turn_off_level) &&
    l11_val(adc.vin) < l11_val(s_q.input_turn_on_level) |=> !s_q.vin_ok)
    else $error("conversion not stopped at turn-off level");
  a_format_ro: assert property (cmd.req && cmd.we && cmd.code == CMD_FMT
    |=> rsp.ack && rsp.err) else $error("format byte write not refused");
  a_ceiling_held: assert property (s_q.ch[0].vset <= s_q.ch[0].ceil &&
    s_q.ch[1].vset <= s_q.ch[1].ceil) else $error("output above ceiling");
  a_ov_fault: assert property (adc.vout_vld[1] && adc.vout[1] > s_q.ch[1].ovf
    |=> s_q.ch[1].f_ov) else $error("output overvoltage fault missed");
  a_busy_bits: assert property (cmd.req && cmd.we && cmd.code == CMD_OVF &&
    s_q.ch[s_q.page].seq != SEQ_OFF |=> (!common[CM_BUSY_A] && !common[CM_BUSY_B])[*8])
    else $error("busy bits not low after limit change");
  a_pulldown: assert property (adc.vout_vld[0] && adc.vout[0] > s_q.ch[0].ovf &&
    overvoltage_pulldown_response[0] |=> !top_gate_drive[0] && bottom_gate_drive[0]
    ##1 !gpio_fault || overvoltage_pulldown_response[1])
    else $error("pulldown response wrong");
  a_ovw_status: assert property (adc.vout_vld[0] && adc.vout[0] > s_q.ch[0].ovw
    |=> sw[0][SW_VOUT] && sb[0][SB_NOA] && sv[0][SV_OVW] && alert)
    else $error("overvoltage warning status missing");
  a_seq_frozen: assert property (s_q.ch[0].seq == SEQ_RISE && $past(s_q.ch[0].seq) == SEQ_RISE
    && $stable(s_q.ch[0].ceil) |-> $stable(s_q.ch[0].goal))
    else $error("goal moved during rise");
  a_ramp_step: assert property (s_q.ch[0].seq == SEQ_ON && !tick_now && s_q.ch[0].vset <=
    s_q.ch[0].ceil && s_q.ch[0].vset <= abs_ceil[0] |=> $stable(s_q.ch[0].vset))
    else $error("output stepped between ramp ticks");
  a_uvw_status: assert property (adc.vout_vld[1] && adc.vout[1] < s_q.ch[1].uvw
    |=> sv[1][SV_UVW] && sw[1][SW_VOUT] && alert) else $error("undervoltage warn missing");
  a_pg_on: assert property (adc.vout_vld[0] && adc.vout[0] >= s_q.ch[0].pgon
    |=> power_good[0]) else $error("power good not asserted");
  a_nom_clamp: assert property (cmd.req && cmd.we && cmd.code == CMD_NOM &&
    cmd.wdata > abs_ceil[s_q.page] |=> s_q.memory_logic_fault &&
    s_q.ch[$past(s_q.page)].nom == abs_ceil[$past(s_q.page)])
    else $error("nominal not clamped");

endmodule

//--- bench/pvl_host_model.sv
// Command host model that drives the voltage limit bank's command port.
`timescale 1ns/10ps
module pvl_host_model
  import pvl_pkg::*;
(
  input wire logic clk,
  output pvl_cmd_s cmd,
  input wire pvl_rsp_s rsp
);
  initial cmd = '0;
  // ==========================================================================
  // Transfers
  // One request pulse; the answer is taken in the following cycle.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r, output logic e);
    @(negedge clk);
    cmd <= '{req: 1'b1, we: w, code: c, wdata: d};
    @(negedge clk);
    cmd <= '0;
    r = rsp.rdata;
    e = rsp.err | !rsp.ack;
  endtask
  // Polling beats a fixed wait when the recalculation runs long.
  task automatic wait_idle(output logic ok);
    logic [15:0] r;
    logic e;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      xfer(1'b0, CMD_COMMON, 16'h0000, r, e);
      ok = (r[CM_BUSY_A] & r[CM_BUSY_B]) === 1'b1;
    end
  endtask
endmodule

//--- bench/pvl_bank_tb_top.sv
// Self-checking testbench of the voltage limit bank.
`timescale 1ns/10ps
module pvl_bank_tb_top
  import pvl_pkg::*;
;
  logic clk, sys_rst, gpio, alert, ok;
  pvl_cmd_s cmd;
  pvl_rsp_s rsp;
  pvl_adc_s adc;
  logic [1:0] run, pd, tg, bg, pg;
  pvl_op_e [1:0] op_mode;
  logic [15:0] ramp_step, r;
  int fails, n_tests;
  pvl_bank #(.RECALC_CYC(20), .TICK_CYC(2)) pvl_bank_inst (.clk(clk), .sys_rst(sys_rst),
    .cmd(cmd), .rsp(rsp), .adc(adc), .run(run), .op_mode(op_mode), .ramp_step(ramp_step),
    .overvoltage_pulldown_response(pd), .top_gate_drive(tg), .bottom_gate_drive(bg),
    .power_good(pg), .gpio_fault(gpio), .alert(alert));
  pvl_host_model pvl_host_model_inst (.clk(clk), .cmd(cmd), .rsp(rsp));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] m, input logic [15:0] x);
    logic e;
    pvl_host_model_inst.xfer(1'b0, c, 16'h0000, r, e);
    chk(16'(e), 16'h0000);
    chk(r & m, x);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic x);
    logic e;
    pvl_host_model_inst.xfer(1'b1, c, d, r, e);
    chk(16'(e), 16'(x));
  endtask
  task automatic vin_s(input logic [15:0] v);
    @(negedge clk);
    adc.vin <= v;
    adc.vin_vld <= 1'b1;
    @(negedge clk);
    adc.vin_vld <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic vo_s(input logic [15:0] v);
    @(negedge clk);
    adc.vout[0] <= v;
    adc.vout_vld <= 2'b01;
    @(negedge clk);
    adc.vout_vld <= 2'b00;
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_tg(input logic v);
    for (int i = 0; i < 200 && tg[0] !== v; i++) @(negedge clk);
    chk(16'(tg[0]), 16'(v));
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd(CMD_FMT, 16'h00ff, 16'h0014);
    wr(CMD_FMT, 16'h0000, 1'b1);
    rd(CMD_NOM, 16'hffff, 16'h1000);
    rd(CMD_MHI, 16'hffff, 16'h10cd);
    rd(CMD_MLO, 16'hffff, 16'h0f33);
    rd(CMD_OVF, 16'hffff, 16'h119a);
    rd(CMD_UVF, 16'hffff, 16'h0e66);
    rd(CMD_PG_ON, 16'hffff, 16'h0ee1);
    rd(CMD_INPUT_TURN_ON_LEVEL, 16'hffff, 16'hcb40);
    rd(CMD_INPUT_TURN_OFF_LEVEL, 16'hffff, 16'hcb00);
    wr(CMD_ABS_CEIL, 16'h0000, 1'b1);
    wr(CMD_PAGE, 16'h0001, 1'b0);
    rd(CMD_CEIL, 16'hffff, 16'h5800);
    rd(CMD_ABS_CEIL, 16'hffff, 16'h5800);
    wr(CMD_NOM, 16'h6000, 1'b0);
    rd(CMD_COMMON, 16'h0001, 16'h0001);
    wr(CMD_PAGE, 16'h0000, 1'b0);
    wr(CMD_CLEAR, 16'h0000, 1'b0);
  endtask
  task automatic t_run();
    run <= 2'b01;
    repeat (10) @(negedge clk);
    chk(16'(tg[0]), 16'h0000);
    vin_s(16'hcb80);
    wait_tg(1'b1);
    vo_s(16'h1000);
    chk(16'(pg[0]), 16'h0001);
    vo_s(16'h1150);
    rd(CMD_STAT_VOUT, 16'h0040, 16'h0040);
    rd(CMD_STAT_WORD, 16'h8001, 16'h8001);
    chk(16'(alert), 16'h0001);
    wr(CMD_CLEAR, 16'h0000, 1'b0);
    vo_s(16'h0e80);
    rd(CMD_STAT_VOUT, 16'h0030, 16'h0020);
    chk(16'(pg[0]), 16'h0000);
    wr(CMD_OVF, 16'h1200, 1'b0);
    rd(CMD_COMMON, 16'h0000, 16'h0000);
    chk(16'(&r[6:5]), 16'h0000);
    pvl_host_model_inst.wait_idle(ok);
    chk(16'(ok), 16'h0001);
  endtask
  task automatic t_fault();
    wr(CMD_CLEAR, 16'h0000, 1'b0);
    vin_s(16'hca00);
    rd(CMD_STAT_WORD, 16'h2000, 16'h2000);
    wait_tg(1'b0);
    vin_s(16'hcb80);
    wait_tg(1'b1);
    pd <= 2'b01;
    vo_s(16'h1300);
    chk({14'h0, tg[0], bg[0]}, 16'h0001);
    chk(16'(gpio), 16'h0000);
    rd(CMD_STAT_VOUT, 16'h0080, 16'h0080);
    wr(CMD_CLEAR, 16'h0000, 1'b0);
    vin_s(16'hd3ff);
    rd(CMD_STAT_WORD, 16'h2000, 16'h2000);
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    adc = '0;
    run = 2'b00;
    pd = 2'b00;
    op_mode = {OP_NOM, OP_NOM};
    ramp_step = 16'h0100;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_run();
    t_fault();
    tally_and_finish();
  end
  initial begin
    #(40 * 5000);
    fails++;
    tally_and_finish();
  end
endmodule
